// ===== logic/reset_power_device.sv
`timescale 1ns/1ps
// Summary of operation
// - Power flag set makes other flags meaningless
// - POR, supply fail, oscillator fail share bit1
// - Bit2 marks last reset was software
// - Upper five status bits read zero
// - Supply monitor reset re-enabled after power-on
// - Software reset re-enabled after any reset
// - Mask blocks supply and software resets separately
// - Host holds reset pin low 15 us
// - Four power modes supported
// - LEDs, pull-ups, monitor individually switchable
// - Transmitter power save active after reset
// - Link detection disables transmitter and pulses
// - Clearing transmitter enable enters link detection
// - Return to normal: write 00, restart
// - Memory mode: only buffers, random access
// - Top bits 000 memory, 111 normal
// - Shutdown leaves only by power-class reset (power-on, supply or oscillator fail) or pin
// - Shutdown sequence order kept by host
// - Oscillator output cleared stops host answers
// - Soft reset bit2 resets, keeps oscillator
module reset_power_device
    import rst_pwr_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    host_port_if.device      hp,
    input  wire logic        supply_fail,
    input  wire logic        osc_fail,
    output rst_pwr_pkg::power_mode_t power_mode,
    output logic             tx_enable,
    output logic             link_pulse_enable,
    output logic             rx_enable,
    output logic             tx_power_save,
    output logic             link_led_en,
    output logic             activity_led_en,
    output logic             weak_pullup_en,
    output logic             supply_monitor_on,
    output logic             osc_out_en,
    output logic             soft_reset_pulse,
    output logic             calibrate_start
);
    import rst_pwr_pkg::*;

    // ======================================================
    // State
    typedef struct packed
    {
        logic [1:0]   pin_sync;
        logic [1:0]   sfail_sync;
        logic [1:0]   ofail_sync;
        logic [7:0]   phy;
        logic [7:0]   io_power_register;
        logic [7:0]   vdm;
        logic [7:0]   osc;
        logic [7:0]   transmitter_power_register;
        logic [7:0]   mask;
        reset_cause_t cause;
        logic         pending_soft;
        logic         pin_seen;
        logic         cold_done;
        logic [7:0]   rdata;
        logic         soft_pulse;
        logic         cal;
    } state_t;

    state_t s_q;
    state_t s_d;

    function automatic power_mode_t mode_of(input logic [7:0] phy, input logic [7:0] osc);
        if (!osc[oscillator_output_enable_pos])
            return mode_shutdown;
        else if (phy[7:5] == 3'b000)
            return mode_memory;
        else if (!phy[transmitter_enable_bit_pos])
            return mode_link_det;
        else
            return mode_normal;
    endfunction : mode_of

    always_comb
    begin
        logic       alive;
        logic       wr_ok;
        logic       rst_req;
        logic [7:0] cause_bits;
        alive      = s_q.osc[oscillator_output_enable_pos];
        wr_ok      = hp.wr && alive;
        cause_bits = 8'h00;
        rst_req    = 1'b0;
        s_d        = s_q;
        s_d.pin_sync   = {s_q.pin_sync[0], hp.rst_pin_n};
        s_d.sfail_sync = {s_q.sfail_sync[0], supply_fail};
        s_d.ofail_sync = {s_q.ofail_sync[0], osc_fail};
        s_d.soft_pulse = 1'b0;
        s_d.cal        = 1'b0;
        unique case (s_q.cause)
            cause_power: cause_bits[power_class_reset_flag_pos] = 1'b1;
            cause_pin:   cause_bits[pin_reset_flag_pos] = 1'b1;
            cause_soft:  cause_bits[soft_reset_flag_pos] = 1'b1;
            cause_none:  cause_bits = 8'h00;
        endcase
        s_d.rdata = 8'h00;
        if (hp.rd && alive)
        begin
            unique case (hp.addr)
                reset_cause_register_addr:       s_d.rdata = cause_bits;
                reset_source_mask_addr:          s_d.rdata = s_q.mask;
                phy_control_register_addr:       s_d.rdata = s_q.phy;
                io_power_register_addr:          s_d.rdata = s_q.io_power_register;
                supply_monitor_control_addr:     s_d.rdata = s_q.vdm;
                oscillator_power_register_addr:  s_d.rdata = s_q.osc;
                transmitter_power_register_addr: s_d.rdata = s_q.transmitter_power_register;
                default:                         s_d.rdata = 8'h00;
            endcase
        end
        if (wr_ok)
        begin
            unique case (hp.addr)
                phy_control_register_addr:       s_d.phy   = hp.wdata;
                io_power_register_addr:          s_d.io_power_register = hp.wdata & 8'h0e;
                supply_monitor_control_addr:     s_d.vdm   = hp.wdata & 8'h80;
                oscillator_power_register_addr:  s_d.osc   = (hp.wdata & 8'h01) | 8'h02;
                transmitter_power_register_addr: s_d.transmitter_power_register = hp.wdata & 8'h80;
                reset_source_mask_addr:          s_d.mask  = hp.wdata & 8'h03;
                default:                         s_d.phy   = s_q.phy;
            endcase
        end
        // Soft trigger waits one cycle so the write answer is clean before the reset.
        s_d.pending_soft = wr_ok && hp.addr == soft_reset_register_addr
                           && hp.wdata[soft_reset_trigger_pos]
                           && !s_q.mask[mask_soft_pos];
        if (!s_q.cold_done)
        begin
            // First cycle after power-on: record the power-class cause
            s_d.cold_done = 1'b1;
            s_d.cause     = cause_power;
        end
        else if (s_q.ofail_sync[1]
                 || (s_q.sfail_sync[1] && s_q.vdm[supply_monitor_enable_pos]
                     && !s_q.mask[mask_supply_pos]))
        begin
            s_d.cause = cause_power;
            s_d.vdm   = supply_mon_reset;
            rst_req   = 1'b1;
        end
        else if (!s_q.pin_sync[1])
        begin
            s_d.pin_seen = 1'b1;
        end
        else if (s_q.pin_seen)
        begin
            // Pin released: reset, and leave shutdown
            s_d.pin_seen = 1'b0;
            s_d.cause    = cause_pin;
            rst_req      = 1'b1;
        end
        else if (s_q.pending_soft)
        begin
            s_d.cause      = cause_soft;
            s_d.soft_pulse = 1'b1;
            s_d.cal        = 1'b1;
            rst_req        = 1'b1;
        end
        if (rst_req)
        begin
            // Software reset keeps the oscillator running.
            s_d.phy   = phy_control_reset;
            s_d.io_power_register = io_power_reset;
            s_d.transmitter_power_register = tx_power_reset;
            s_d.mask  = mask_reset;
            // A soft request taken in this cycle survives the reset: the set wins.
            s_d.osc   = osc_power_reset;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s_q <= '{pin_sync: 2'b11, sfail_sync: 2'b00, ofail_sync: 2'b00,
                     phy: phy_control_reset, io_power_register: io_power_reset, vdm: supply_mon_reset,
                     osc: osc_power_reset, transmitter_power_register: tx_power_reset, mask: mask_reset,
                     cause: cause_none, pending_soft: 1'b0,
                     pin_seen: 1'b0, cold_done: 1'b0, rdata: 8'h00,
                     soft_pulse: 1'b0, cal: 1'b0};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Outputs are decodes of registered state only.
    power_mode_t pm_q;
    logic [9:0]  outs_q;
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pm_q   <= mode_memory;
            outs_q <= 10'h000;
        end
        else
        begin
            pm_q   <= mode_of(s_d.phy, s_d.osc);
            outs_q <= {s_d.phy[transmitter_enable_bit_pos] && s_d.osc[0],
                       s_d.phy[transmitter_enable_bit_pos] && s_d.osc[0],
                       s_d.phy[7] && s_d.osc[0],
                       !s_d.transmitter_power_register[tx_power_save_off_pos],
                       s_d.io_power_register[link_led_pos] && s_d.osc[0],
                       s_d.io_power_register[activity_led_pos] && s_d.osc[0],
                       !s_d.io_power_register[weak_pullup_off_pos],
                       s_d.vdm[supply_monitor_enable_pos],
                       s_d.osc[oscillator_output_enable_pos],
                       s_d.cal};
        end
    end

    assign power_mode        = pm_q;
    assign tx_enable         = outs_q[9];
    assign link_pulse_enable = outs_q[8];
    assign rx_enable         = outs_q[7];
    assign tx_power_save     = outs_q[6];
    assign link_led_en       = outs_q[5];
    assign activity_led_en   = outs_q[4];
    assign weak_pullup_en    = outs_q[3];
    assign supply_monitor_on = outs_q[2];
    assign osc_out_en        = outs_q[1];
    assign calibrate_start   = outs_q[0];
    assign soft_reset_pulse  = s_q.soft_pulse;
    assign hp.rdata          = s_q.rdata;

endmodule : reset_power_device

// ===== logic/rst_pwr_pkg.sv
package rst_pwr_pkg;

    // ======================================================
    // Register offsets
    localparam logic [7:0] supply_monitor_control_addr    = 8'h13;
    localparam logic [7:0] io_power_register_addr         = 8'h70;
    localparam logic [7:0] reset_cause_register_addr      = 8'h73;
    localparam logic [7:0] reset_source_mask_addr         = 8'h74;
    localparam logic [7:0] soft_reset_register_addr       = 8'h75;
    localparam logic [7:0] phy_control_register_addr      = 8'h78;
    localparam logic [7:0] transmitter_power_register_addr = 8'h7a;
    localparam logic [7:0] oscillator_power_register_addr = 8'h7c;

    // ======================================================
    // Field positions
    localparam int pin_reset_flag_pos         = 0;
    localparam int power_class_reset_flag_pos = 1;
    localparam int soft_reset_flag_pos        = 2;
    localparam int soft_reset_trigger_pos     = 2;
    localparam int mask_supply_pos            = 0;
    localparam int mask_soft_pos              = 1;
    localparam int transmitter_enable_bit_pos = 6;
    localparam int weak_pullup_off_pos        = 1;
    localparam int link_led_pos               = 2;
    localparam int activity_led_pos           = 3;
    localparam int supply_monitor_enable_pos  = 7;
    localparam int oscillator_output_enable_pos = 0;
    localparam int tx_power_save_off_pos      = 7;

    // ======================================================
    // Reset values and oscillator read mask
    localparam logic [7:0] phy_control_reset   = 8'h00;
    localparam logic [7:0] io_power_reset      = 8'h00;
    localparam logic [7:0] supply_mon_reset    = 8'h80;
    localparam logic [7:0] osc_power_reset     = 8'h03;
    localparam logic [7:0] osc_power_read_mask = 8'h03;
    localparam logic [7:0] tx_power_reset      = 8'h00;
    localparam logic [7:0] mask_reset          = 8'h00;

    // ======================================================
    // Timing
    localparam int clk_period_ps        = 5000;
    localparam int pin_low_min_us       = 15;
    localparam int pin_low_min_cycles   = (pin_low_min_us * 1000000 + clk_period_ps - 1) / clk_period_ps;
    localparam int pin_low_cnt_w        = 12;

    typedef enum logic [1:0]
    {
        mode_normal   = 2'b00,
        mode_link_det = 2'b01,
        mode_memory   = 2'b10,
        mode_shutdown = 2'b11
    } power_mode_t;

    typedef enum logic [1:0]
    {
        cause_none  = 2'b00,
        cause_power = 2'b01,
        cause_pin   = 2'b10,
        cause_soft  = 2'b11
    } reset_cause_t;

endpackage : rst_pwr_pkg

// ===== logic/host_port_if.sv
`timescale 1ns/1ps
interface host_port_if;
    logic       rst_pin_n;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;

    modport device
    (
        input  rst_pin_n,
        input  addr,
        input  wdata,
        input  wr,
        input  rd,
        output rdata
    );

    modport host
    (
        output rst_pin_n,
        output addr,
        output wdata,
        output wr,
        output rd,
        input  rdata
    );
endinterface : host_port_if

// ===== logic/reset_power_host.sv
`timescale 1ns/1ps
module reset_power_host
    import rst_pwr_pkg::*;
#(
    parameter int pin_low_cycles = pin_low_min_cycles
)
(
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    host_port_if.host        hp,
    input  wire logic [7:0]  cmd_addr,
    input  wire logic [7:0]  cmd_wdata,
    input  wire logic        cmd_wr,
    input  wire logic        cmd_rd,
    output logic      [7:0]  cmd_rdata,
    output logic             busy
);
    import rst_pwr_pkg::*;

    // ======================================================
    // Local ports: 0xf0 write = pulse reset pin; others pass through
    localparam logic [7:0] pin_pulse_addr = 8'hf0;

    typedef struct packed
    {
        logic [7:0]  addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
        logic        rd_d;
        logic [7:0]  rdata;
        logic        pin_n;
        logic [pin_low_cnt_w-1:0] cnt;
    } state_t;

    state_t s_q;
    state_t s_d;

    always_comb
    begin
        s_d    = s_q;
        s_d.wr = 1'b0;
        s_d.rd = 1'b0;
        s_d.rd_d = s_q.rd;
        if (s_q.rd_d)
            s_d.rdata = hp.rdata;
        if (!s_q.pin_n)
        begin
            // Hold pin low for the least time
            if (s_q.cnt == pin_low_cnt_w'(pin_low_cycles - 1))
                s_d.pin_n = 1'b1;
            else
                s_d.cnt = s_q.cnt + 1'b1;
        end
        else if (cmd_wr && cmd_addr == pin_pulse_addr)
        begin
            s_d.pin_n = 1'b0;
            s_d.cnt   = '0;
        end
        else if (cmd_wr || cmd_rd)
        begin
            // Host software orders: 0x00 before restart shutdown order
            s_d.addr  = cmd_addr;
            s_d.wdata = cmd_wdata;
            s_d.wr    = cmd_wr;
            s_d.rd    = cmd_rd;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            s_q <= '{addr: 8'h00, wdata: 8'h00, wr: 1'b0, rd: 1'b0, rd_d: 1'b0,
                     rdata: 8'h00, pin_n: 1'b1, cnt: '0};
        else
            s_q <= s_d;
    end

    assign hp.addr      = s_q.addr;
    assign hp.wdata     = s_q.wdata;
    assign hp.wr        = s_q.wr;
    assign hp.rd        = s_q.rd;
    assign hp.rst_pin_n = s_q.pin_n;
    assign cmd_rdata    = s_q.rdata;
    assign busy         = !s_q.pin_n;

endmodule : reset_power_host

// ===== verification/reset_power_properties.sv
`timescale 1ns/1ps
module reset_power_properties
#(
    parameter int pin_low_cycles = 4
)
(
    input wire logic       clk_sys,
    input wire logic       reset_n,
    input wire logic       rst_pin_n,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata,
    input wire logic       supply_fail,
    input wire logic       osc_fail
);
    import rst_pwr_pkg::*;

    // ==================================================
    // Shadow model; cause, mask, monitor and oscillator reads are judged only after a quiet spell
    logic [2:0]  cause_q;
    logic [1:0]  mask_q;
    logic        mon_q;
    logic        dead_q;
    logic [2:0]  quiet_q;
    logic [15:0] low_q;
    logic        take;
    logic        soft_ev;
    logic        fail_ev;

    assign take    = wr && !dead_q;
    assign soft_ev = take && addr == soft_reset_register_addr && wdata[2] && !mask_q[mask_soft_pos];
    assign fail_ev = osc_fail || (supply_fail && mon_q && !mask_q[mask_supply_pos]);

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cause_q <= 3'h2;
            mask_q  <= 2'h0;
            mon_q   <= 1'b1;
            dead_q  <= 1'b0;
            quiet_q <= 3'h0;
        end
        else if (!rst_pin_n || soft_ev || fail_ev)
        begin
            cause_q <= !rst_pin_n ? 3'h1 : (soft_ev ? 3'h4 : 3'h2);
            mask_q  <= 2'h0;
            // Only a power-class reset turns the monitor back on
            mon_q   <= fail_ev ? 1'b1 : mon_q;
            dead_q  <= 1'b0;
            quiet_q <= 3'h0;
        end
        else
        begin
            quiet_q <= (quiet_q == 3'h7) ? quiet_q : quiet_q + 3'h1;
            if (take && addr == reset_source_mask_addr)
                mask_q <= wdata[1:0];
            if (take && addr == supply_monitor_control_addr)
                mon_q <= wdata[supply_monitor_enable_pos];
            if (take && addr == oscillator_power_register_addr && !wdata[0])
                dead_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            low_q <= 16'h0000;
        else if (rst_pin_n)
            low_q <= 16'h0000;
        else
            low_q <= low_q + 16'h0001;
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    sequence quiet_read(logic [7:0] a);
        rd && addr == a && !dead_q && quiet_q == 3'h7;
    endsequence

    read_idle_zero_a: assert property (!rd |=> rdata == 8'h00)
        else $error("read data not zero outside a read answer");
    status_upper_zero_a: assert property (rd && addr == reset_cause_register_addr |=> rdata[7:3] == 5'h00)
        else $error("status upper bits not zero");
    status_cause_a: assert property (quiet_read(reset_cause_register_addr) |=> rdata[2:0] == $past(cause_q))
        else $error("status cause bits wrong");
    mask_read_a: assert property (quiet_read(reset_source_mask_addr) |=> rdata[1:0] == $past(mask_q))
        else $error("reset mask read wrong");
    monitor_read_a: assert property (quiet_read(supply_monitor_control_addr) |=> rdata[7] == $past(mon_q))
        else $error("supply monitor enable read wrong");
    osc_read_a: assert property (quiet_read(oscillator_power_register_addr) |=> rdata[1:0] == 2'b11)
        else $error("oscillator enable read wrong");
    dead_silent_a: assert property (rd && dead_q |=> rdata == 8'h00)
        else $error("device answered after oscillator output cleared");
    pin_hold_a: assert property ($rose(rst_pin_n) |-> low_q >= 16'(pin_low_cycles))
        else $error("reset pin low time too short");
endmodule : reset_power_properties

// ===== verification/reset_source_and_power_modes_bench.sv
`timescale 1ns/1ps
module reset_source_and_power_modes_bench;
    import rst_pwr_pkg::*;

    logic        clk_sys;
    logic        reset_n;
    logic        supply_fail;
    logic        osc_fail;
    logic [7:0]  cmd_addr;
    logic [7:0]  cmd_wdata;
    logic        cmd_wr;
    logic        cmd_rd;
    logic [7:0]  cmd_rdata;
    logic        busy;
    power_mode_t power_mode;
    logic        tx_enable;
    logic        link_pulse_enable;
    logic        rx_enable;
    logic        soft_reset_pulse;
    logic        tx_power_save;
    logic        link_led_en;
    logic        activity_led_en;
    logic        weak_pullup_en;
    logic        supply_monitor_on;
    logic        osc_out_en;
    logic        calibrate_start;
    int          error_cnt = 0;
    int          check_count = 0;
    int          cal_cnt = 0;
    int          soft_cnt = 0;

    host_port_if hp_bus ();

    reset_power_device u_reset_power_device
    (
        .clk_sys           (clk_sys),
        .reset_n           (reset_n),
        .hp                (hp_bus.device),
        .supply_fail       (supply_fail),
        .osc_fail          (osc_fail),
        .power_mode        (power_mode),
        .tx_enable         (tx_enable),
        .link_pulse_enable (link_pulse_enable),
        .rx_enable         (rx_enable),
        .tx_power_save     (tx_power_save),
        .link_led_en       (link_led_en),
        .activity_led_en   (activity_led_en),
        .weak_pullup_en    (weak_pullup_en),
        .supply_monitor_on (supply_monitor_on),
        .osc_out_en        (osc_out_en),
        .soft_reset_pulse  (soft_reset_pulse),
        .calibrate_start   (calibrate_start)
    );

    reset_power_host #(.pin_low_cycles(4)) u_reset_power_host
    (
        .clk_sys   (clk_sys),
        .reset_n   (reset_n),
        .hp        (hp_bus.host),
        .cmd_addr  (cmd_addr),
        .cmd_wdata (cmd_wdata),
        .cmd_wr    (cmd_wr),
        .cmd_rd    (cmd_rd),
        .cmd_rdata (cmd_rdata),
        .busy      (busy)
    );

    reset_power_properties #(.pin_low_cycles(4)) u_props
    (
        .clk_sys     (clk_sys),
        .reset_n     (reset_n),
        .rst_pin_n   (hp_bus.rst_pin_n),
        .addr        (hp_bus.addr),
        .wdata       (hp_bus.wdata),
        .wr          (hp_bus.wr),
        .rd          (hp_bus.rd),
        .rdata       (hp_bus.rdata),
        .supply_fail (supply_fail),
        .osc_fail    (osc_fail)
    );

    initial
    begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys)
        if (calibrate_start === 1'b1)
            cal_cnt <= cal_cnt + 1;

    always @(posedge clk_sys)
        if (soft_reset_pulse === 1'b1)
            soft_cnt <= soft_cnt + 1;

    // ==================================================
    // Tasks
    task automatic conclude();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : conclude

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic host_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        cmd_addr <= a;
        cmd_wdata <= d;
        cmd_wr <= 1'b1;
        @(posedge clk_sys);
        cmd_wr <= 1'b0;
        repeat (8) @(posedge clk_sys);
    endtask : host_wr

    // Command sampled, bus strobe, device answer, host capture: look after the third edge
    task automatic rd_check(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge clk_sys);
        cmd_addr <= a;
        cmd_rd   <= 1'b1;
        @(posedge clk_sys);
        cmd_rd   <= 1'b0;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        check($sformatf("reg %h", a), cmd_rdata & m, e);
        repeat (2) @(posedge clk_sys);
    endtask : rd_check

    task automatic pin_reset();
        int n;
        host_wr(8'hf0, 8'h00);
        n = 0;
        while (busy !== 1'b0 && n < 100)
        begin
            @(posedge clk_sys);
            n++;
        end
        repeat (10) @(posedge clk_sys);
    endtask : pin_reset

    task automatic fail_pulse(input int k);
        @(posedge clk_sys);
        if (k == 0)
            supply_fail <= 1'b1;
        else
            osc_fail <= 1'b1;
        repeat (4) @(posedge clk_sys);
        supply_fail <= 1'b0;
        osc_fail <= 1'b0;
        repeat (12) @(posedge clk_sys);
    endtask : fail_pulse

    // ==================================================
    // Scenarios
    localparam logic [7:0] phy_val [4] = '{8'he0, 8'ha0, 8'h00, 8'he0};
    localparam power_mode_t mode_exp [4] = '{mode_normal, mode_link_det, mode_memory, mode_normal};

    initial
    begin
        logic [7:0] v;
        int         s;
        int         t;
        {cmd_addr, cmd_wdata, cmd_wr, cmd_rd} = 18'h00000;
        {supply_fail, osc_fail, reset_n} = 3'b000;
        s = $urandom(69);
        repeat (6) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rd_check(reset_cause_register_addr, 8'hff, 8'h02);
        rd_check(reset_source_mask_addr, 8'h03, 8'h00);
        rd_check(supply_monitor_control_addr, 8'h80, 8'h80);
        rd_check(oscillator_power_register_addr, osc_power_read_mask, osc_power_reset);
        check("tx_power_save", {7'h00, tx_power_save}, 8'h01);
        host_wr(reset_cause_register_addr, 8'hff);
        rd_check(reset_cause_register_addr, 8'hff, 8'h02);
        pin_reset();
        rd_check(reset_cause_register_addr, 8'hff, 8'h01);
        host_wr(reset_source_mask_addr, 8'h02);
        host_wr(soft_reset_register_addr, 8'h04);
        rd_check(reset_cause_register_addr, 8'hff, 8'h01);
        rd_check(reset_source_mask_addr, 8'h03, 8'h02);
        for (int k = 0; k < 2; k++)
        begin
            s = cal_cnt;
            t = soft_cnt;
            host_wr(reset_source_mask_addr, 8'h01);
            host_wr(soft_reset_register_addr, 8'h04);
            rd_check(reset_cause_register_addr, 8'hff, 8'h04);
            rd_check(reset_source_mask_addr, 8'h03, 8'h00);
            check("calibrate", 8'(cal_cnt - s), 8'h01);
            check("soft_pulse", 8'(soft_cnt - t), 8'h01);
            host_wr(reset_source_mask_addr, 8'h01);
            fail_pulse(0);
            rd_check(reset_cause_register_addr, 8'hff, 8'h04);
            host_wr(reset_source_mask_addr, 8'h00);
            fail_pulse(k);
            rd_check(reset_cause_register_addr, 8'hff, 8'h02);
        end
        for (int k = 0; k < 4; k++)
        begin
            host_wr(phy_control_register_addr, phy_val[k]);
            check("power_mode", {6'h00, power_mode}, {6'h00, mode_exp[k]});
            check("tx_enable", {7'h00, tx_enable}, {7'h00, phy_val[k][6]});
            check("link_pulse", {7'h00, link_pulse_enable}, {7'h00, phy_val[k][6]});
            check("rx_enable", {7'h00, rx_enable}, {7'h00, phy_val[k][7]});
        end
        host_wr(transmitter_power_register_addr, 8'h80);
        check("tx_power_save", {7'h00, tx_power_save}, 8'h00);
        for (int k = 0; k < 4; k++)
        begin
            v = 8'($urandom) & 8'h8e;
            host_wr(io_power_register_addr, v & 8'h0e);
            host_wr(supply_monitor_control_addr, v & 8'h80);
            check("secondary", {supply_monitor_on, 3'h0, activity_led_en, link_led_en, !weak_pullup_en, 1'b0}, v);
        end
        host_wr(phy_control_register_addr, 8'h00);
        host_wr(io_power_register_addr, 8'h00);
        host_wr(supply_monitor_control_addr, 8'h00);
        host_wr(oscillator_power_register_addr, 8'h00);
        check("shutdown", {5'h00, power_mode, osc_out_en}, {5'h00, mode_shutdown, 1'b0});
        s = cal_cnt;
        t = soft_cnt;
        host_wr(soft_reset_register_addr, 8'h04);
        rd_check(reset_cause_register_addr, 8'hff, 8'h00);
        check("calibrate", 8'(cal_cnt - s), 8'h00);
        check("soft_pulse", 8'(soft_cnt - t), 8'h00);
        pin_reset();
        rd_check(reset_cause_register_addr, 8'hff, 8'h01);
        check("osc_out_en", {7'h00, osc_out_en}, 8'h01);
        conclude();
    end

    initial
    begin
        #100000;
        error_cnt++;
        conclude();
    end
endmodule : reset_source_and_power_modes_bench
